// ==== verilog/rcs_pkg.sv ====
package rcs_pkg;

	// APB register map, byte addresses
	localparam int              ADDR_W          = 12;
	localparam logic [11:0]     ADDR_RESET_CTRL = 12'h000;
	localparam logic [11:0]     ADDR_STACK      = 12'h004;
	localparam logic [11:0]     ADDR_CTRL       = 12'h008;
	localparam logic [11:0]     ADDR_STATUS     = 12'h00C;
	localparam logic [11:0]     ADDR_STACK_TOP  = 12'h010;

	// Reset control register fields
	localparam int              BIT_BROWNOUT    = 0;
	localparam int              BIT_POWERON     = 1;
	localparam int              BIT_POWERDOWN   = 2;
	localparam int              BIT_WDT_TIMEOUT = 3;
	localparam int              BIT_RESET_INSTR = 4;
	localparam int              BIT_CFG_MISMATCH = 5;
	localparam int              BIT_INT_PRIO    = 7;
	localparam logic [5:0]      FLAGS_POR       = 6'h3C;
	localparam logic            INT_PRIO_RST    = 1'h0;

	// Stack register fields
	localparam int              SP_W            = 5;
	localparam int              BIT_STK_UNF     = 6;
	localparam int              BIT_STK_FUL     = 7;
	localparam logic [4:0]      SP_RST          = 5'h00;
	localparam logic [4:0]      SP_MAX          = 5'h1F;

	// Control register fields
	localparam int              BIT_STACK_OVERFLOW_RESET_ENABLE      = 0;
	localparam logic            STACK_OVERFLOW_RESET_ENABLE_RST      = 1'h1;

	// Program counter values
	localparam int              PC_W            = 21;
	localparam logic [20:0]     PC_RESET        = 21'h000000;
	localparam logic [20:0]     PC_STEP         = 21'h000002;
	localparam logic [20:0]     VEC_HIGH        = 21'h000008;
	localparam logic [20:0]     VEC_LOW         = 21'h000018;

	// Power-up timer length in oscillator ticks
	localparam int              POWERUP_TIMER_TICKS      = 2048;

	typedef enum logic [1:0] {
		PM_FULL  = 2'b00,
		PM_RUN   = 2'b01,
		PM_IDLE  = 2'b10,
		PM_SLEEP = 2'b11
	} rcs_pm_mode_e;

	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_HOLD    = 2'b01,
		ST_RUN     = 2'b10,
		ST_RESTART = 2'b11
	} rcs_state_e;

endpackage

// ==== verilog/rcs_powerup_timer_if.sv ====
`timescale 1ns/1ns
interface rcs_powerup_timer_if;
	logic restart;
	logic tick;
	logic expired;
	modport ctl (output restart, output tick, input expired);
	modport tmr (input restart, input tick, output expired);
endinterface

// ==== verilog/rcs_powerup_timer.sv ====
`timescale 1ns/1ns
module rcs_powerup_timer
	import rcs_pkg::*;
#(
	parameter int TICKS = POWERUP_TIMER_TICKS
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	rcs_powerup_timer_if.tmr   tmr
);
	localparam int            CW   = $clog2(TICKS);
	localparam logic [CW-1:0] LAST = CW'(TICKS - 1);
	localparam logic [CW-1:0] ZERO = '0;

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          done;
	logic          next_done;

	always_comb begin
		next_count = count;
		next_done  = done;
		if (tmr.restart) begin
			next_count = ZERO;
			next_done  = 1'b0;
		end else if (!done && tmr.tick) begin
			if (count == LAST) begin
				next_count = ZERO;
				next_done  = 1'b1;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	// Counting starts on its own once the power-on reset lets go
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end

	assign tmr.expired = done;
endmodule

// ==== verilog/rcs_top.sv ====
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module rcs_top
	import rcs_pkg::*;
#(
	parameter int CFG_WORDS  = 8,
	parameter int CFG_BITS   = 8,
	parameter int POWERUP_TIMER_COUNT = POWERUP_TIMER_TICKS
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      master_clear_pin,
	input  wire logic                      brownout_det,
	input  wire logic                      internal_rc_osc,
	input  wire logic [CFG_WORDS*CFG_BITS-1:0] cfg_value,
	input  wire logic [CFG_WORDS*CFG_BITS-1:0] cfg_shadow,
	input  wire logic [1:0]                pm_mode,
	input  wire logic [PC_W-1:0]           pc_now,
	input  wire logic                      global_int_enable_high,
	input  wire logic                      global_int_enable_low,
	input  wire logic                      reset_instr_evt,
	input  wire logic                      stack_overflow_evt,
	input  wire logic                      stack_underflow_evt,
	input  wire logic                      wdt_timeout_evt,
	input  wire logic                      int_wake_evt,
	output logic                           core_reset,
	output logic                           pc_load,
	output logic [PC_W-1:0]                pc_target,
	output logic                           cfg_reload
);
	rcs_powerup_timer_if powerup_timer ();

	rcs_powerup_timer #(
		.TICKS (POWERUP_TIMER_COUNT)
	) u_powerup_timer (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tmr     (powerup_timer)
	);

	// Pin and oscillator synchronisers
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       rc_prev;
	logic       master_clear_pin_s;
	logic       bor_s;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// Brownout resets to its idle level: no false event at release
			sync_a  <= 3'h5;
			sync_b  <= 3'h5;
			rc_prev <= 1'b1;
		end else begin
			sync_a  <= {internal_rc_osc, brownout_det, master_clear_pin};
			sync_b  <= sync_a;
			rc_prev <= sync_b[2];
		end
	end

	assign master_clear_pin_s    = sync_b[0];
	assign bor_s     = sync_b[1];
	assign powerup_timer.tick = sync_b[2] & ~rc_prev;

	// Config pair compare, one comparator per word
	logic [CFG_WORDS-1:0] word_bad;
	logic                 mismatch;

	genvar gi;
	generate
		for (gi = 0; gi < CFG_WORDS; gi++) begin : g_cmp
			assign word_bad[gi] = cfg_value[gi*CFG_BITS +: CFG_BITS] !=
				~cfg_shadow[gi*CFG_BITS +: CFG_BITS];
		end
	endgenerate
	assign mismatch = |word_bad;

	rcs_state_e       state;
	rcs_state_e       next_state;
	logic [5:0]       flags;
	logic [5:0]       next_flags;
	logic             int_prio;
	logic             next_int_prio;
	logic [SP_W-1:0]  stk_ptr;
	logic [SP_W-1:0]  next_stk_ptr;
	logic             stk_full;
	logic             next_stk_full;
	logic             stk_unf;
	logic             next_stk_unf;
	logic [PC_W-1:0]  stack_top;
	logic [PC_W-1:0]  next_stack_top;
	logic             stack_overflow_reset_enable;
	logic             next_stack_overflow_reset_enable;
	logic             next_core_reset;
	logic             next_pc_load;
	logic [PC_W-1:0]  next_pc_target;
	logic             next_cfg_reload;
	logic             next_restart;
	logic             restart_q;
	logic [31:0]      next_prdata;
	logic             next_pready;
	logic             next_pslverr;
	logic             bus_wr;
	logic             bus_rd;
	logic             asleep;
	logic             hard_rst;

	assign bus_wr = psel & penable & pwrite & pready;
	assign bus_rd = psel & penable & ~pready;
	assign asleep = (pm_mode == PM_IDLE) || (pm_mode == PM_SLEEP);
	assign powerup_timer.restart = restart_q;

	always_comb begin
		next_state      = state;
		next_flags      = flags;
		next_int_prio   = int_prio;
		next_stk_ptr    = stk_ptr;
		next_stk_full   = stk_full;
		next_stk_unf    = stk_unf;
		next_stack_top  = stack_top;
		next_stack_overflow_reset_enable     = stack_overflow_reset_enable;
		next_core_reset = core_reset;
		next_pc_load    = 1'b0;
		next_pc_target  = pc_target;
		next_cfg_reload = 1'b0;
		next_restart    = 1'b0;
		hard_rst        = 1'b0;
		next_prdata     = prdata;
		next_pready     = bus_rd;
		next_pslverr    = 1'b0;

		// Software side first so that hardware events win below
		if (bus_rd) begin
			next_prdata = 32'h00000000;
			case (paddr)
			ADDR_RESET_CTRL: begin
				next_prdata[BIT_INT_PRIO] = int_prio;
				next_prdata[5:0]          = flags;
			end
			ADDR_STACK: begin
				next_prdata[BIT_STK_FUL]  = stk_full;
				next_prdata[BIT_STK_UNF]  = stk_unf;
				next_prdata[SP_W-1:0]     = stk_ptr;
			end
			ADDR_CTRL: next_prdata[BIT_STACK_OVERFLOW_RESET_ENABLE] = stack_overflow_reset_enable;
			ADDR_STATUS: next_prdata[5:0] = {mismatch, powerup_timer.expired,
				master_clear_pin_s, bor_s, state};
			ADDR_STACK_TOP: next_prdata[PC_W-1:0] = stack_top;
			default: next_pslverr = 1'b1;
			endcase
		end
		if (bus_wr) begin
			case (paddr)
			ADDR_RESET_CTRL: begin
				next_int_prio = pwdata[BIT_INT_PRIO];
				next_flags    = pwdata[5:0];
			end
			ADDR_STACK: begin
				next_stk_full = pwdata[BIT_STK_FUL];
				next_stk_unf  = pwdata[BIT_STK_UNF];
				next_stk_ptr  = pwdata[SP_W-1:0];
			end
			ADDR_CTRL: next_stack_overflow_reset_enable = pwdata[BIT_STACK_OVERFLOW_RESET_ENABLE];
			default: ;
			endcase
		end

		case (state)
		ST_POWERUP: begin
			next_core_reset = 1'b1;
			if (powerup_timer.expired && !bor_s) begin
				next_state = master_clear_pin_s ? ST_RUN : ST_HOLD;
				next_core_reset = ~master_clear_pin_s;
				next_pc_load    = master_clear_pin_s;
				next_pc_target  = PC_RESET;
			end
		end
		ST_HOLD: begin
			// Timer already done: run from the very release edge
			if (master_clear_pin_s) begin
				next_state      = ST_RUN;
				next_core_reset = 1'b0;
				next_pc_load    = 1'b1;
				next_pc_target  = PC_RESET;
			end
		end
		ST_RESTART: begin
			next_state      = ST_RUN;
			next_core_reset = 1'b0;
			next_pc_load    = 1'b1;
			next_pc_target  = PC_RESET;
		end
		ST_RUN: begin
			if (!master_clear_pin_s) begin
				hard_rst   = 1'b1;
				next_state = ST_HOLD;
				if (pm_mode == PM_RUN) begin
					next_flags[BIT_WDT_TIMEOUT] = 1'b1;
				end else if (asleep) begin
					next_flags[BIT_WDT_TIMEOUT] = 1'b1;
					next_flags[BIT_POWERDOWN]   = 1'b0;
				end
				// Full power keeps every flag as it is
			end else if (mismatch) begin
				hard_rst   = 1'b1;
				next_state = ST_RESTART;
				next_flags[BIT_CFG_MISMATCH] = 1'b0;
			end else if (wdt_timeout_evt && asleep) begin
				next_flags[BIT_WDT_TIMEOUT] = 1'b0;
				next_flags[BIT_POWERDOWN]   = 1'b0;
				next_pc_load   = 1'b1;
				next_pc_target = pc_now + PC_STEP;
			end else if (wdt_timeout_evt) begin
				hard_rst   = 1'b1;
				next_state = ST_RESTART;
				next_flags[BIT_WDT_TIMEOUT] = 1'b0;
			end else if (reset_instr_evt) begin
				hard_rst   = 1'b1;
				next_state = ST_RESTART;
				next_flags[BIT_RESET_INSTR] = 1'b0;
			end else if (stack_overflow_evt) begin
				next_stk_full = 1'b1;
				if (stack_overflow_reset_enable) begin
					hard_rst   = 1'b1;
					next_state = ST_RESTART;
				end
			end else if (stack_underflow_evt) begin
				next_stk_unf = 1'b1;
				if (stack_overflow_reset_enable) begin
					hard_rst   = 1'b1;
					next_state = ST_RESTART;
				end
			end else if (int_wake_evt && pm_mode != PM_FULL) begin
				next_flags[BIT_POWERDOWN] = 1'b0;
				next_pc_load = 1'b1;
				if (global_int_enable_high || global_int_enable_low) begin
					next_pc_target = global_int_enable_high ?
						VEC_HIGH : VEC_LOW;
					next_stack_top = pc_now;
					if (stk_ptr == SP_MAX) begin
						next_stk_full = 1'b1;
					end else begin
						next_stk_ptr = stk_ptr + 1'b1;
					end
				end else begin
					next_pc_target = pc_now + PC_STEP;
				end
			end
		end
		default: next_state = ST_POWERUP;
		endcase

		// Hard resets zero the stack pointer and top and reload config; full/underflow bits and flags stay
		if (hard_rst) begin
			next_core_reset = 1'b1;
			next_cfg_reload = 1'b1;
			next_int_prio   = INT_PRIO_RST;
			next_stk_ptr    = SP_RST;
			next_stack_top  = PC_RESET;
		end

		// Brownout holds the core in reset and rearms the timer each cycle
		if (bor_s) begin
			next_state      = ST_POWERUP;
			next_restart    = 1'b1;
			next_core_reset = 1'b1;
			next_cfg_reload = 1'b1;
			next_pc_load    = 1'b0;
			next_int_prio   = INT_PRIO_RST;
			next_stk_ptr    = SP_RST;
			next_stack_top  = PC_RESET;
			next_flags[BIT_RESET_INSTR] = 1'b1;
			next_flags[BIT_WDT_TIMEOUT] = 1'b1;
			next_flags[BIT_POWERDOWN]   = 1'b1;
			next_flags[BIT_BROWNOUT]    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_POWERUP;
			flags      <= FLAGS_POR;
			int_prio   <= INT_PRIO_RST;
			stk_ptr    <= SP_RST;
			stk_full   <= 1'b0;
			stk_unf    <= 1'b0;
			stack_top  <= PC_RESET;
			stack_overflow_reset_enable     <= STACK_OVERFLOW_RESET_ENABLE_RST;
			core_reset <= 1'b1;
			pc_load    <= 1'b0;
			pc_target  <= PC_RESET;
			cfg_reload <= 1'b1;
			restart_q  <= 1'b0;
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			state      <= next_state;
			flags      <= next_flags;
			int_prio   <= next_int_prio;
			stk_ptr    <= next_stk_ptr;
			stk_full   <= next_stk_full;
			stk_unf    <= next_stk_unf;
			stack_top  <= next_stack_top;
			stack_overflow_reset_enable     <= next_stack_overflow_reset_enable;
			core_reset <= next_core_reset;
			pc_load    <= next_pc_load;
			pc_target  <= next_pc_target;
			cfg_reload <= next_cfg_reload;
			restart_q  <= next_restart;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
		end
	end
endmodule

// ==== verification/rcs_props.sv ====
`timescale 1ns/1ns
module rcs_props
	import rcs_pkg::*;
#(
	parameter int CFG_WORDS  = 8,
	parameter int CFG_BITS   = 8,
	parameter int POWERUP_TIMER_COUNT = POWERUP_TIMER_TICKS
) (
	input wire logic                          clk_sys,
	input wire logic                          rst_b,
	input wire logic                          brownout_det,
	input wire logic                          internal_rc_osc,
	input wire logic                          master_clear_pin,
	input wire logic [CFG_WORDS*CFG_BITS-1:0] cfg_value,
	input wire logic [CFG_WORDS*CFG_BITS-1:0] cfg_shadow,
	input wire logic [1:0]                    pm_mode,
	input wire logic [PC_W-1:0]               pc_now,
	input wire logic                          wdt_timeout_evt,
	input wire logic                          int_wake_evt,
	input wire logic                          global_int_enable_high,
	input wire logic                          core_reset,
	input wire logic                          pc_load,
	input wire logic [PC_W-1:0]               pc_target,
	input wire logic                          cfg_reload
);
	logic        osc_q;
	logic        rl;
	logic        next_rl;
	logic [11:0] ticks;
	logic [11:0] next_ticks;

	always_comb begin
		next_rl = core_reset ? (rl | cfg_reload) : cfg_reload;
		next_ticks = ticks;
		// Raw edges lead the synced ones, so this bounds the design's count
		if (brownout_det) begin
			next_ticks = 12'h000;
		end else if (internal_rc_osc && !osc_q && ticks != 12'hFFF) begin
			next_ticks = ticks + 12'h001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_q <= 1'b0;
			rl    <= 1'b1;
			ticks <= 12'h000;
		end else begin
			osc_q <= internal_rc_osc;
			rl    <= next_rl;
			ticks <= next_ticks;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_mismatch;
		cfg_shadow != ~cfg_value && !core_reset && master_clear_pin
			|-> ##[1:3] core_reset;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("mismatch did not reset");
	property p_reload;
		$fell(core_reset) |-> rl || cfg_reload;
	endproperty
	a_reload: assert property (p_reload)
		else $error("restart without config reload");
	property p_timer;
		$fell(core_reset) |-> ticks >= POWERUP_TIMER_COUNT;
	endproperty
	a_timer: assert property (p_timer)
		else $error("reset left before timer expiry");
	property p_release;
		$rose(master_clear_pin) && ticks > POWERUP_TIMER_COUNT |-> ##[1:8] !core_reset;
	endproperty
	a_release: assert property (p_release)
		else $error("no run after pin release");
	property p_restart;
		$fell(core_reset) |-> pc_load && pc_target == PC_RESET;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart not at address zero");
	property p_wdt_run;
		wdt_timeout_evt && !pm_mode[1] && !core_reset
			|=> core_reset ##1 (!core_reset && pc_load);
	endproperty
	a_wdt_run: assert property (p_wdt_run)
		else $error("watchdog reset timing wrong");
	property p_wdt_sleep;
		wdt_timeout_evt && pm_mode[1] && !core_reset
			|=> !core_reset && pc_load && pc_target == pc_now + PC_STEP;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep)
		else $error("watchdog wake target wrong");
	property p_int_high;
		int_wake_evt && pm_mode != PM_FULL && global_int_enable_high
			&& !core_reset |=> pc_load && pc_target == VEC_HIGH;
	endproperty
	a_int_high: assert property (p_int_high)
		else $error("high vector not taken");

	cover property (pc_load && pc_target == VEC_LOW);
	cover property ($fell(core_reset) && ticks > POWERUP_TIMER_COUNT);
	cover property (wdt_timeout_evt && pm_mode[1]);
endmodule

// ==== verification/rcs_partner.sv ====
`timescale 1ns/1ns
module rcs_partner (
	input  wire logic hold_low,
	output logic      master_clear_pin,
	output logic      internal_rc_osc
);
	// Pin has a pull-up, so a released driver reads high
	assign master_clear_pin = !hold_low;

	// Free-running, unrelated in phase to the system clock
	initial internal_rc_osc = 1'b0;
	always #41 internal_rc_osc = ~internal_rc_osc;
endmodule

// ==== verification/rcs_top_tb.sv ====
`timescale 1ns/1ns
module rcs_top_tb
	import rcs_pkg::*;
;
	localparam logic [20:0] PCN = 21'h000ABC;
	localparam logic [20:0] PC2 = PCN + PC_STEP;
	typedef struct {
		logic [5:0]  base;
		logic [2:0]  ev;
		logic [1:0]  pm;
		logic [1:0]  gie;
		logic [5:0]  reset_control_reg;
		logic [20:0] pc;
		logic [7:0]  stk;
	} rcs_row_s;
	// ev: 0 pin, 1 mismatch, 2 reset instr, 3 ovf, 4 unf, 5 wdt, 6 int
	rcs_row_s rows [15] = '{
		'{6'h15, 3'h0, PM_FULL, 2'h0, 6'h15, PC_RESET, 8'h00},
		'{6'h15, 3'h0, PM_RUN, 2'h0, 6'h1D, PC_RESET, 8'h00},
		'{6'h37, 3'h0, PM_IDLE, 2'h0, 6'h3B, PC_RESET, 8'h00},
		'{6'h37, 3'h0, PM_SLEEP, 2'h0, 6'h3B, PC_RESET, 8'h00},
		'{6'h3F, 3'h5, PM_FULL, 2'h0, 6'h37, PC_RESET, 8'h00},
		'{6'h3F, 3'h5, PM_RUN, 2'h0, 6'h37, PC_RESET, 8'h00},
		'{6'h3F, 3'h5, PM_IDLE, 2'h0, 6'h33, PC2, 8'h00},
		'{6'h3F, 3'h5, PM_SLEEP, 2'h0, 6'h33, PC2, 8'h00},
		'{6'h3F, 3'h6, PM_IDLE, 2'h0, 6'h3B, PC2, 8'h00},
		'{6'h3F, 3'h6, PM_SLEEP, 2'h2, 6'h3B, VEC_HIGH, 8'h01},
		'{6'h3F, 3'h6, PM_RUN, 2'h1, 6'h3B, VEC_LOW, 8'h01},
		'{6'h3F, 3'h2, PM_FULL, 2'h0, 6'h2F, PC_RESET, 8'h00},
		'{6'h3F, 3'h1, PM_FULL, 2'h0, 6'h1F, PC_RESET, 8'h00},
		'{6'h3F, 3'h3, PM_FULL, 2'h0, 6'h3F, PC_RESET, 8'h80},
		'{6'h3F, 3'h4, PM_FULL, 2'h0, 6'h3F, PC_RESET, 8'h40}
	};
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready;
	logic        pslverr;
	logic        e;
	logic        hold_low = 1'b1;
	logic        brownout_det = 1'b0;
	logic [63:0] cfg_value = 64'hA5C3_0F96_5A3C_F069;
	logic [63:0] cfg_shadow = ~64'hA5C3_0F96_5A3C_F069;
	logic [1:0]  pm = PM_FULL;
	logic [1:0]  gie = 2'h0;
	logic [4:0]  ev_p = 5'h00;
	logic        master_clear_pin;
	logic        internal_rc_osc;
	logic        core_reset;
	logic        pc_load;
	logic        cfg_reload;
	logic [20:0] pc_target;
	int          n_errors = 0;
	int          tests_run = 0;
	int          n;

	always #2 clk_sys = ~clk_sys;

	rcs_partner u_rcs_partner (.hold_low(hold_low),
		.master_clear_pin(master_clear_pin),
		.internal_rc_osc(internal_rc_osc));

	rcs_top #(.POWERUP_TIMER_COUNT(16)) u_rcs_top (.clk_sys(clk_sys), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_clear_pin(master_clear_pin),
		.brownout_det(brownout_det), .internal_rc_osc(internal_rc_osc),
		.cfg_value(cfg_value), .cfg_shadow(cfg_shadow), .pm_mode(pm),
		.pc_now(PCN), .global_int_enable_high(gie[1]),
		.global_int_enable_low(gie[0]), .reset_instr_evt(ev_p[0]),
		.stack_overflow_evt(ev_p[1]), .stack_underflow_evt(ev_p[2]),
		.wdt_timeout_evt(ev_p[3]), .int_wake_evt(ev_p[4]),
		.core_reset(core_reset), .pc_load(pc_load),
		.pc_target(pc_target), .cfg_reload(cfg_reload));

	task automatic summarize;
		if (n_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic wait_pl(input int lim);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pc_load !== 1'b1 && n < lim);
		if (pc_load !== 1'b1) begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic fire(input logic [2:0] ev);
		if (ev == 3'h0) begin
			hold_low <= 1'b1;
			repeat (10) @(posedge clk_sys);
			hold_low <= 1'b0;
		end else if (ev == 3'h1) begin
			cfg_shadow[0] <= ~cfg_shadow[0];
			@(posedge clk_sys);
			cfg_shadow[0] <= ~cfg_shadow[0];
		end else begin
			ev_p[ev-3'h2] <= 1'b1;
			@(posedge clk_sys);
			ev_p <= 5'h00;
		end
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (500) @(posedge clk_sys);
		chk(core_reset, 1'b1);
		hold_low <= 1'b0;
		wait_pl(50);
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk(q, 32'h3C);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(q, 32'h1);
		foreach (rows[i]) begin
			pm <= rows[i].pm;
			gie <= rows[i].gie;
			apb(1'b1, ADDR_RESET_CTRL, {26'h0, rows[i].base});
			apb(1'b1, ADDR_STACK, 32'h0);
			fire(rows[i].ev);
			wait_pl(100);
			chk(pc_target, rows[i].pc);
			apb(1'b0, ADDR_RESET_CTRL, 32'h0);
			chk(q[5:0], rows[i].reset_control_reg);
			apb(1'b0, ADDR_STACK, 32'h0);
			chk(q[7:0], rows[i].stk);
			if (rows[i].gie != 2'h0) begin
				apb(1'b0, ADDR_STACK_TOP, 32'h0);
				chk(q, {11'h0, PCN});
			end
		end
		apb(1'b0, 12'h020, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_STACK, 32'h0);
		fire(3'h4);
		n = 0;
		repeat (20) begin
			@(posedge clk_sys);
			if (pc_load === 1'b1) n++;
		end
		chk(n, 32'h0);
		apb(1'b0, ADDR_STACK, 32'h0);
		chk(q[7:0], 8'h40);
		apb(1'b1, ADDR_RESET_CTRL, 32'h0);
		brownout_det <= 1'b1;
		repeat (10) @(posedge clk_sys);
		brownout_det <= 1'b0;
		repeat (100) @(posedge clk_sys);
		brownout_det <= 1'b1;
		repeat (5) @(posedge clk_sys);
		brownout_det <= 1'b0;
		wait_pl(1000);
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk(q[5:0], 6'h1C);
		summarize();
	end
endmodule

bind rcs_top rcs_props #(.CFG_WORDS(CFG_WORDS), .CFG_BITS(CFG_BITS),
	.POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT)) u_rcs_props (.clk_sys(clk_sys), .rst_b(rst_b),
	.brownout_det(brownout_det), .internal_rc_osc(internal_rc_osc),
	.master_clear_pin(master_clear_pin), .cfg_value(cfg_value),
	.cfg_shadow(cfg_shadow), .pm_mode(pm_mode), .pc_now(pc_now),
	.wdt_timeout_evt(wdt_timeout_evt), .int_wake_evt(int_wake_evt),
	.global_int_enable_high(global_int_enable_high),
	.core_reset(core_reset), .pc_load(pc_load), .pc_target(pc_target),
	.cfg_reload(cfg_reload));
